// ==== logic/csup_pkg.sv ====
// Constants and types for the supervisor with serial memory
package csup_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_KHZ     = 100000;
   localparam int unsigned RST_DLY_MS  = 250;
   localparam int unsigned WR_CYC_MS   = 5;
   localparam int unsigned WD_T0_MS    = 1400;
   localparam int unsigned WD_T1_MS    = 600;
   localparam int unsigned WD_T2_MS    = 200;
   localparam int unsigned RST_DLY_CYC = RST_DLY_MS * CLK_KHZ;
   localparam int unsigned WR_CYC_CYC  = WR_CYC_MS * CLK_KHZ;
   localparam int unsigned WD_T0_CYC   = WD_T0_MS * CLK_KHZ;
   localparam int unsigned WD_T1_CYC   = WD_T1_MS * CLK_KHZ;
   localparam int unsigned WD_T2_CYC   = WD_T2_MS * CLK_KHZ;
   // ****************************************
   // Memory and 2-wire addressing
   // ****************************************
   localparam int unsigned PAGE_BYTES  = 64;
   localparam int unsigned PAGES       = 64;
   localparam int unsigned MEM_BYTES   = 4096;
   localparam logic [3:0]  DEV_TYPE    = 4'ha;
   localparam int unsigned CTL_SPACE   = 15;
   localparam logic [7:0]  CTL_LO      = 8'hff;
   localparam logic [7:0]  TRIP_LO     = 8'hfe;
   localparam logic [1:0]  WD_OFF      = 2'h3;
   localparam logic [2:0]  LOCK_ALL    = 3'h5;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  REG_STATUS  = 8'h00;
   localparam logic [7:0]  REG_MASK    = 8'h04;
   localparam logic [7:0]  REG_CTRL    = 8'h08;
   localparam logic [7:0]  REG_STATE   = 8'h0c;
   localparam int unsigned EV_WD       = 0;
   localparam int unsigned EV_LOW      = 1;
   localparam int unsigned EV_WDONE    = 2;
   localparam logic [2:0]  MASK_RST    = 3'h0;
   localparam logic [1:0]  TRIP_DEF    = 2'h0;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic       write_guard_enable_bit;
      logic [1:0] spare;
      logic [2:0] lock;
      logic [1:0] wd;
   } csup_ctrl_t;
   localparam csup_ctrl_t CTRL_DEF = 8'h00;
   typedef struct packed {
      logic s1;
      logic s0;
      logic vcc;
      logic wp;
      logic scl;
      logic sda;
   } csup_pins_t;
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       act;
   } csup_ap_t;
   typedef enum logic [2:0] {TW_IDLE, TW_DEV, TW_AHI, TW_ALO, TW_WDATA, TW_RDATA} csup_tw_t;
endpackage

// ==== logic/csup_top.sv ====
// Supervisor: reset timer, watchdog, 2-wire memory slave, AHB-Lite registers
//
// Functional notes
// - Reset held until supply good 250ms
// - Power-up reset lasts 250ms after stable
// - Enabled watchdog expiry asserts reset
// - SDA fall with SCL high restarts watchdog
// - Three selectable watchdog intervals
// - Watchdog selection kept non-volatile
// - Open-drain reset, low or high variant
// - SDA watched always, ungated
// - WP high plus guard bit blocks control writes
// - Page writes up to 64 bytes
// - Self-timed 5ms write cycle
// - Lock 1,2,4,8 pages, all, none
// - Trip level changed by special sequence
`timescale 1ns/1ps
module csup_top import csup_pkg::*; #(
   parameter int unsigned RST_DLY  = RST_DLY_CYC,
   parameter int unsigned WR_CYC   = WR_CYC_CYC,
   parameter int unsigned WD_T0    = WD_T0_CYC,
   parameter int unsigned WD_T1    = WD_T1_CYC,
   parameter int unsigned WD_T2    = WD_T2_CYC,
   parameter bit          ACT_HIGH = 1'b0
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   // 2-wire bus and straps
   input  wire logic        scl,
   input  wire logic        sda_pin,
   output logic             sda_drv,
   output logic             sda_oe,
   input  wire logic        chip_select_strap_0,
   input  wire logic        chip_select_strap_1,
   input  wire logic        write_protect,
   // Supply sense and reset pin
   input  wire logic        vcc_ok,
   output logic             rst_drv,
   output logic             rst_oe,
   output logic      [1:0]  vtrip_code
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   csup_pins_t meta_r, sync_r;
   logic       sda_d_r, scl_d_r, vcc_d_r;
   wire csup_pins_t pins_in = '{s1: chip_select_strap_1, s0: chip_select_strap_0,
      vcc: vcc_ok, wp: write_protect, scl: scl, sda: sda_pin};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r  <= '1;
         sync_r  <= '1;
         sda_d_r <= 1'b1;
         scl_d_r <= 1'b1;
         vcc_d_r <= 1'b1;
      end else begin
         meta_r  <= pins_in;
         sync_r  <= meta_r;
         sda_d_r <= sync_r.sda;
         scl_d_r <= sync_r.scl;
         vcc_d_r <= sync_r.vcc;
      end
   end
   wire scl_hi   = scl_d_r && sync_r.scl;
   wire start_ev = scl_hi && sda_d_r && !sync_r.sda;
   wire stop_ev  = scl_hi && !sda_d_r && sync_r.sda;
   wire scl_rise = !scl_d_r && sync_r.scl;
   wire scl_fall = scl_d_r && !sync_r.scl;
   wire low_ev   = vcc_d_r && !sync_r.vcc;

   // ****************************************
   // Non-volatile state and functions
   // ****************************************
   csup_ctrl_t nv_ctrl_r = CTRL_DEF;
   logic [1:0] nv_trip_r = TRIP_DEF;
   logic [7:0] mem [MEM_BYTES];
   logic [7:0] pg_r [PAGE_BYTES];

   function automatic logic [31:0] wd_limit(input logic [1:0] sel);
      if (sel == 2'h0) return WD_T0;
      if (sel == 2'h1) return WD_T1;
      return WD_T2;
   endfunction

   function automatic logic page_locked(input logic [5:0] pg, input logic [2:0] code);
      logic [6:0] span;
      span = 7'h01 << (code - 3'h1);
      if (code == 3'h0) return 1'b0;
      if (code >= LOCK_ALL) return 1'b1;
      return {1'b0, pg} >= 7'(PAGES) - span;
   endfunction

   // ****************************************
   // Reset timer and watchdog
   // ****************************************
   logic [31:0] dly_cnt_r, wd_cnt_r;
   logic        rst_act_r;
   wire wd_on   = nv_ctrl_r.wd != WD_OFF;
   wire wd_fire = wd_on && !rst_act_r && wd_cnt_r == wd_limit(nv_ctrl_r.wd) - 32'h1;
   wire dly_end = dly_cnt_r == 32'(RST_DLY - 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_act_r <= 1'b1;
         dly_cnt_r <= '0;
      end else if (!sync_r.vcc || wd_fire) begin
         rst_act_r <= 1'b1;
         dly_cnt_r <= '0;
      end else if (rst_act_r) begin
         rst_act_r <= !dly_end;
         dly_cnt_r <= dly_end ? '0 : dly_cnt_r + 32'h1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wd_cnt_r <= '0;
      end else if (!wd_on || rst_act_r || start_ev || wd_fire) begin
         wd_cnt_r <= '0;
      end else begin
         wd_cnt_r <= wd_cnt_r + 32'h1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_oe  <= 1'b1;
         rst_drv <= 1'b0;
      end else begin
         rst_oe  <= rst_act_r ^ ACT_HIGH;
         rst_drv <= 1'b0;
      end
   end

   // ****************************************
   // 2-wire slave
   // ****************************************
   csup_tw_t    st_r;
   logic [3:0]  bit_r;
   logic        ack_ph_r, busy_r, ctrl_pend_r, trip_pend_r;
   logic [7:0]  rx_r, tx_r, ctrl_val_r;
   logic [15:0] addr_r;
   logic [1:0]  trip_val_r;
   logic [PAGE_BYTES-1:0] pg_v_r;
   logic [31:0] wcnt_r;
   wire rd      = st_r == TW_RDATA;
   wire [7:0] rd_byte = mem[addr_r[11:0]];
   wire sel_ok  = rx_r[7:4] == DEV_TYPE && !busy_r
                  && rx_r[2:1] == {sync_r.s1, sync_r.s0};
   wire ack_ok  = st_r != TW_DEV || sel_ok;
   wire byte_in = scl_fall && !ack_ph_r && bit_r == 4'h8 && st_r == TW_WDATA;
   wire is_ctl  = addr_r[CTL_SPACE];
   wire ctl_ok  = !(sync_r.wp && nv_ctrl_r.write_guard_enable_bit);
   wire trip_ok = sync_r.wp && !nv_ctrl_r.write_guard_enable_bit;
   wire pg_we   = byte_in && !is_ctl;
   wire pend    = |pg_v_r || ctrl_pend_r || trip_pend_r;
   wire wr_go   = stop_ev && st_r == TW_WDATA && !busy_r && pend;
   wire wr_end  = busy_r && wcnt_r == 32'(WR_CYC - 1);
   wire [5:0] wptr = wcnt_r[5:0];
   wire mem_we  = busy_r && wcnt_r < 32'(PAGE_BYTES) && pg_v_r[wptr]
                  && !page_locked(addr_r[11:6], nv_ctrl_r.lock);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r     <= TW_IDLE;
         bit_r    <= '0;
         ack_ph_r <= 1'b0;
         sda_oe   <= 1'b0;
         sda_drv  <= 1'b0;
         rx_r     <= '0;
         tx_r     <= '0;
         addr_r   <= '0;
      end else if (start_ev) begin
         st_r     <= TW_DEV;
         bit_r    <= '0;
         ack_ph_r <= 1'b0;
         sda_oe   <= 1'b0;
      end else if (stop_ev) begin
         st_r     <= TW_IDLE;
         ack_ph_r <= 1'b0;
         sda_oe   <= 1'b0;
      end else if (st_r != TW_IDLE && scl_rise) begin
         if (bit_r == 4'h8) begin
            bit_r <= '0;
            if (rd && sync_r.sda) st_r <= TW_IDLE;
         end else begin
            rx_r  <= {rx_r[6:0], sync_r.sda};
            bit_r <= bit_r + 4'h1;
         end
      end else if (st_r != TW_IDLE && scl_fall) begin
         if (ack_ph_r) begin
            ack_ph_r <= 1'b0;
            sda_oe   <= rd && !rd_byte[7];
            tx_r     <= {rd_byte[6:0], 1'b0};
            if (rd) addr_r <= addr_r + 16'h1;
         end else if (bit_r == 4'h8) begin
            ack_ph_r <= 1'b1;
            sda_oe   <= !rd && ack_ok;
            case (st_r)
               TW_DEV: st_r <= !sel_ok ? TW_IDLE : (rx_r[0] ? TW_RDATA : TW_AHI);
               TW_AHI: begin
                  addr_r[15:8] <= rx_r;
                  st_r         <= TW_ALO;
               end
               TW_ALO: begin
                  addr_r[7:0] <= rx_r;
                  st_r        <= TW_WDATA;
               end
               TW_WDATA: if (!is_ctl) addr_r[5:0] <= addr_r[5:0] + 6'h1;
               default: ;
            endcase
         end else if (rd && bit_r != 4'h0) begin
            sda_oe <= !tx_r[7];
            tx_r   <= {tx_r[6:0], 1'b0};
         end
      end
   end

   // ****************************************
   // Self-timed write cycle
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_r      <= 1'b0;
         wcnt_r      <= '0;
         pg_v_r      <= '0;
         ctrl_pend_r <= 1'b0;
         trip_pend_r <= 1'b0;
         ctrl_val_r  <= '0;
         trip_val_r  <= '0;
      end else begin
         if (wr_go) begin
            busy_r <= 1'b1;
            wcnt_r <= '0;
         end else if (wr_end) begin
            busy_r <= 1'b0;
         end else if (busy_r) begin
            wcnt_r <= wcnt_r + 32'h1;
         end
         if (wr_end || (start_ev && !busy_r)) begin
            pg_v_r      <= '0;
            ctrl_pend_r <= 1'b0;
            trip_pend_r <= 1'b0;
         end else if (byte_in && is_ctl) begin
            if (addr_r[7:0] == CTL_LO && ctl_ok) begin
               ctrl_pend_r <= 1'b1;
               ctrl_val_r  <= rx_r;
            end
            if (addr_r[7:0] == TRIP_LO && trip_ok) begin
               trip_pend_r <= 1'b1;
               trip_val_r  <= rx_r[1:0];
            end
         end else if (pg_we) begin
            pg_v_r[addr_r[5:0]] <= 1'b1;
         end
      end
   end
   always_ff @(posedge hclk) begin
      if (pg_we) pg_r[addr_r[5:0]] <= rx_r;
      if (mem_we) mem[{addr_r[11:6], wptr}] <= pg_r[wptr];
      if (wr_end && ctrl_pend_r) nv_ctrl_r <= ctrl_val_r;
      if (wr_end && trip_pend_r) nv_trip_r <= trip_val_r;
   end
   assign vtrip_code = nv_trip_r;

   // ****************************************
   // AHB-Lite registers and interrupt
   // ****************************************
   csup_ap_t   ap_r;
   logic [2:0] status_r, mask_r;
   wire ap_act = hsel && htrans[1] && hready;
   wire rd_hit = ap_act && !hwrite;
   wire [2:0] ev_set = {wr_end, low_ev, wd_fire};
   wire st_clr = rd_hit && haddr[7:0] == REG_STATUS;
   wire [31:0] rd_mux =
      haddr[7:0] == REG_STATUS ? {29'h0, status_r} :
      haddr[7:0] == REG_MASK   ? {29'h0, mask_r} :
      haddr[7:0] == REG_CTRL   ? {22'h0, nv_trip_r, nv_ctrl_r} :
      haddr[7:0] == REG_STATE  ? {28'h0, busy_r, wd_on, rst_act_r, sync_r.vcc} : 32'h0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_r      <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         status_r  <= '0;
         mask_r    <= MASK_RST;
         irq       <= 1'b0;
      end else begin
         ap_r      <= '{addr: haddr[7:0], wr: hwrite, act: ap_act};
         hrdata    <= rd_hit ? rd_mux : '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         status_r  <= (st_clr ? 3'h0 : status_r) | ev_set;
         if (ap_r.act && ap_r.wr && ap_r.addr == REG_MASK) mask_r <= hwdata[2:0];
         irq       <= |(status_r & mask_r);
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_wr_start;
      wr_go;
   endsequence
   sequence s_release;
      rst_act_r ##1 !rst_act_r;
   endsequence
   chk_low_supply_rst: assert property (!sync_r.vcc |=> rst_act_r)
      else $error("reset not held while supply low");
   chk_release_delay: assert property (s_release |-> $past(dly_cnt_r) == 32'(RST_DLY - 1))
      else $error("reset released before delay ended");
   chk_wd_expiry: assert property (wd_fire |=> rst_act_r && dly_cnt_r == 0)
      else $error("watchdog expiry did not assert reset");
   chk_wd_restart: assert property (start_ev && !wd_fire |=> wd_cnt_r == 0)
      else $error("watchdog not restarted by SDA fall");
   chk_wd_interval: assert property ($rose(rst_act_r) && $past(wd_on && sync_r.vcc)
      |-> $past(wd_cnt_r) == wd_limit(nv_ctrl_r.wd) - 32'h1)
      else $error("watchdog fired at wrong count");
   chk_pin_drive: assert property (##1 rst_oe == ($past(rst_act_r) ^ ACT_HIGH) && !rst_drv)
      else $error("reset pin drive wrong");
   chk_wp_guard: assert property ($rose(ctrl_pend_r) |-> $past(ctl_ok))
      else $error("control write taken while guarded");
   chk_wr_cycle: assert property (s_wr_start |=> busy_r [*8])
      else $error("write cycle ended early");
   chk_lock_block: assert property (mem_we |-> !page_locked(addr_r[11:6], nv_ctrl_r.lock))
      else $error("write into locked page");
   chk_strap_match: assert property (st_r == TW_DEV && scl_fall && bit_r == 4'h8 && !ack_ph_r
      && !sel_ok && !start_ev && !stop_ev |=> !sda_oe)
      else $error("acknowledged foreign address");
endmodule

// ==== tb/csup_host.sv ====
// Two-wire bus host model with open-drain data line
`timescale 1ns/1ps
module csup_host (
   // Clock and bus
   input  wire logic hclk,
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda
);
   // ****************************************
   // Bus phases
   // ****************************************
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge hclk);
   endtask
   task automatic start();
      cyc(2);
      sda <= 1'b1;
      cyc(6);
      scl <= 1'b1;
      cyc(8);
      sda <= 1'b0;
      cyc(8);
      scl <= 1'b0;
   endtask
   task automatic stop();
      cyc(2);
      sda <= 1'b0;
      cyc(6);
      scl <= 1'b1;
      cyc(8);
      sda <= 1'b1;
      cyc(8);
   endtask
   task automatic bits(input logic [8:0] o, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         cyc(2);
         sda <= o[i];
         cyc(6);
         scl <= 1'b1;
         cyc(8);
         r[i] = sda_in;
         scl <= 1'b0;
      end
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Testbench for the supervisor with serial memory
`timescale 1ns/1ps
module tb_top;
   import csup_pkg::*;
   localparam int RD = 200;
   localparam int T0 = 1000;
   localparam int T2 = 300;
   logic        hclk, hresetn, hsel, hwrite, vcc_ok, wp, s0, s1;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, vtrip_code;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, irq, sda_drv, sda_oe, rst_drv, rst_oe;
   logic        scl, sda_h, sda_pin, rst_pin, a;
   logic [8:0]  r;
   logic [15:0] lf;
   logic [7:0]  mem [3];
   int          n_fail, check_count, n;
   assign sda_pin = sda_h & ~(sda_oe & ~sda_drv);
   assign rst_pin = rst_oe ? rst_drv : 1'b1;
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   csup_top #(.RST_DLY(RD), .WR_CYC(600), .WD_T0(T0), .WD_T1(600), .WD_T2(T2)) i_csup_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .scl(scl),
      .sda_pin(sda_pin), .sda_drv(sda_drv), .sda_oe(sda_oe), .chip_select_strap_0(s0),
      .chip_select_strap_1(s1), .write_protect(wp), .vcc_ok(vcc_ok), .rst_drv(rst_drv),
      .rst_oe(rst_oe), .vtrip_code(vtrip_code));
   csup_host i_csup_host (.hclk(hclk), .sda_in(sda_pin), .scl(scl), .sda(sda_h));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] nx(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [7:0] dev(input logic rw);
      return {DEV_TYPE, 1'b0, s1, s0, rw};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic edge_rdy();
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) begin
         n_fail++;
         stop_test();
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, ad};
      hwrite <= w;
      edge_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      rd = hrdata;
      check(hresp, 1'b0);
   endtask
   task automatic wait_rst(input logic lvl, input int lim);
      n = 0;
      while (rst_pin !== lvl && n < lim) begin
         @(posedge hclk);
         n++;
      end
      if (rst_pin !== lvl) begin
         n_fail++;
         stop_test();
      end
   endtask
   task automatic tx(input logic [7:0] b);
      i_csup_host.bits({b, 1'b1}, r);
      a = ~r[0];
   endtask
   task automatic poll();
      n = 0;
      do begin
         i_csup_host.start();
         tx(dev(1'b0));
         i_csup_host.stop();
         n++;
      end while (!a && n < 20);
      check(a, 1'b1);
   endtask
   task automatic wr(input logic [15:0] ad, input int cnt);
      i_csup_host.start();
      tx(dev(1'b0));
      tx(ad[15:8]);
      tx(ad[7:0]);
      for (int i = 0; i < cnt; i++) tx(mem[i]);
      i_csup_host.stop();
      poll();
   endtask
   task automatic rd_mem(input logic [15:0] ad);
      i_csup_host.start();
      tx(dev(1'b0));
      tx(ad[15:8]);
      tx(ad[7:0]);
      i_csup_host.start();
      tx(dev(1'b1));
      i_csup_host.bits(9'h1ff, r);
      i_csup_host.stop();
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {hresetn, hsel, hwrite, wp, n_fail, check_count} = '0;
      {haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      vcc_ok = 1'b1;
      lf = nx(16'd61);
      s0 = lf[0];
      s1 = lf[1];
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      check(rst_pin, 1'b0);
      wait_rst(1'b1, 2000);
      check(n >= RD && n <= RD + 8, 1'b1);
      ahb(1'b0, REG_MASK, 32'h0);
      check(rd, 32'h0);
      ahb(1'b0, REG_STATE, 32'h0);
      check(rd, 32'h5);
      check({sda_drv, rst_drv}, 2'h0);
      lf = nx(lf);
      ahb(1'b1, REG_MASK, {16'h0, lf});
      ahb(1'b0, REG_MASK, 32'h0);
      check(rd, {29'h0, lf[2:0]});
      ahb(1'b1, 8'h10, 32'hffffffff);
      ahb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, REG_MASK, 32'h2);
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         repeat (600) @(posedge hclk);
         i_csup_host.start();
         i_csup_host.stop();
      end
      ahb(1'b0, REG_STATUS, 32'h0);
      check(rd[0], 1'b0);
      wait_rst(1'b0, 1100);
      check(n >= T0 - 60 && n <= T0 + 8, 1'b1);
      check(irq, 1'b0);
      wait_rst(1'b1, 300);
      ahb(1'b0, REG_STATUS, 32'h0);
      check(rd[2:0], 3'h1);
      $display("watchdog done");
      for (int i = 0; i < 3; i++) begin
         lf = nx(lf);
         mem[i] = lf[7:0];
      end
      wr(16'h003e, 3);
      check(n >= 3 && n <= 5, 1'b1);
      ahb(1'b0, REG_STATUS, 32'h0);
      check(rd[2], 1'b1);
      for (int i = 0; i < 3; i++) begin
         rd_mem(i == 2 ? 16'h0000 : 16'h003e + i[15:0]);
         check(r[8:1], mem[i]);
      end
      i_csup_host.start();
      tx(dev(1'b0) ^ 8'h02);
      i_csup_host.stop();
      check(a, 1'b0);
      $display("memory done");
      mem[0] = 8'h14;
      wr(16'h80ff, 1);
      mem[0] = ~mem[2];
      wr(16'h0000, 1);
      rd_mem(16'h0000);
      check(r[8:1], mem[2]);
      wp <= 1'b1;
      mem[0] = 8'h02;
      wr(16'h80fe, 1);
      check(vtrip_code, 2'h2);
      wp <= 1'b0;
      mem[0] = 8'h82;
      wr(16'h80ff, 1);
      wp <= 1'b1;
      mem[0] = 8'h03;
      wr(16'h80ff, 1);
      ahb(1'b0, REG_CTRL, 32'h0);
      check(rd, 32'h282);
      $display("control done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      wait_rst(1'b1, 300);
      ahb(1'b0, REG_CTRL, 32'h0);
      check(rd, 32'h282);
      wait_rst(1'b0, 400);
      check(n >= T2 - 8 && n <= T2 + 8, 1'b1);
      wait_rst(1'b1, 300);
      ahb(1'b1, REG_MASK, 32'h2);
      vcc_ok <= 1'b0;
      repeat (6) @(posedge hclk);
      check(rst_pin, 1'b0);
      check(irq, 1'b1);
      vcc_ok <= 1'b1;
      wait_rst(1'b1, 400);
      check(n >= RD && n <= RD + 8, 1'b1);
      ahb(1'b0, REG_STATUS, 32'h0);
      check(rd[1], 1'b1);
      @(posedge hclk);
      check(irq, 1'b0);
      $display("supply done");
      stop_test();
   end
endmodule
